// ===== core/vt_supervision.sv
// Voltage transformer supervision logic with an AHB-Lite register slave.
//
// Overview of operation
// RULE1: Negative sequence voltage without negative sequence current raises the supervision condition.
// RULE2: Voltage threshold fixed at 10V; current inhibit settable 0.05In to 0.5In.
// RULE3: Superimposed current is present sample minus the sample one cycle earlier.
// RULE4: All three voltages collapsed with no superimposed current raises the condition.
// RULE5: Phase voltage detectors drop off below 10V, pick up above 30V.
// RULE6: Superimposed current detectors pick up at a fixed 0.1In.
// RULE7: Energisation with voltages absent blocks only if overcurrent detector not operated.
// RULE8: Energisation path works only while pole dead logic reports live line.
// RULE9: Energisation overcurrent threshold settable 0.08In to 32In, default 10In.
// RULE10: Block latches after condition persists for 1s to 10s delay, default 5s.
// RULE11: Before latching inhibits override the block; after latching faults cannot.
// RULE12: Manual reset mode clears latch on command only when condition has gone.
// RULE13: Automatic reset mode clears latch when all three voltages are restored.
// RULE14: Indication only mode alarms without blocking; blocking mode is default.
// RULE15: Supervision indication rises when the delay expires in either mode.
// RULE16: In indication only mode a trip raises the indication early.
// RULE17: In blocking mode each voltage element is blocked per its own link.
// RULE18: Directional to non-directional conversion only available in blocking mode.
// RULE19: Breaker auxiliary disconnect input produces the block directly.
// RULE20: Superimposed current is checked per phase; any phase inhibits three phase detector.
//
// Our own choices: the AHB-Lite interface to the registers and the address map.
`default_nettype none
module vt_supervision
    import vt_supervision_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    sys_rst,
    input  wire logic                    sample_valid,
    input  wire logic [15:0]             phase_voltage_a,
    input  wire logic [15:0]             phase_voltage_b,
    input  wire logic [15:0]             phase_voltage_c,
    input  wire logic [15:0]             phase_current_a,
    input  wire logic [15:0]             phase_current_b,
    input  wire logic [15:0]             phase_current_c,
    input  wire logic [15:0]             neg_seq_voltage,
    input  wire logic [15:0]             neg_seq_current,
    input  wire logic                    live_line,
    input  wire logic                    breaker_aux_disconnect_input,
    input  wire logic                    trip_signal,
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    output logic [31:0]                  hrdata,
    output logic                         hreadyout,
    output logic                         hresp,
    output logic                         vt_supervision_block,
    output logic                         vt_supervision_alarm,
    output logic [NUM_ELEMENTS-1:0]      element_block,
    output logic                         nondirectional_convert
);
    // Settings and control.
    logic                    indicate_q;
    logic                    auto_q;
    logic                    nondir_q;
    logic [15:0]             neg_i_inh_q;
    logic [15:0]             oc_inh_q;
    logic [15:0]             delay_q;
    logic [NUM_ELEMENTS-1:0] links_q;
    logic                    reset_cmd_q;
    // Bus pipeline.
    logic                    wr_pend_q;
    logic [7:0]              addr_q;
    logic [31:0]             hrdata_q;
    // Detection state.
    logic [2:0]              v_live_q;
    logic [2:0]              delta_q;
    logic [15:0]             hist_a [CYCLE_SAMPLES];
    logic [15:0]             hist_b [CYCLE_SAMPLES];
    logic [15:0]             hist_c [CYCLE_SAMPLES];
    logic [$clog2(CYCLE_SAMPLES)-1:0] hist_ptr_q;
    logic [$clog2(CYCLE_SAMPLES):0]   hist_fill_q;
    sup_state_t              state_q;
    logic [15:0]             step_cnt_q;
    logic [23:0]             cyc_cnt_q;
    logic                    early_ind_q;
    logic                    block_q;
    logic                    alarm_q;
    logic [NUM_ELEMENTS-1:0] elem_q;
    logic                    nondir_out_q;
    wire                     cond_any;

    // Bus decode.
    wire        bus_take   = hsel && hready && htrans[1];
    wire [7:0]  word_addr  = {haddr[7:2], 2'b00};
    wire        wr_ctrl    = wr_pend_q && (addr_q == REG_CTRL);
    wire        wr_neg_i   = wr_pend_q && (addr_q == REG_NEG_I_INH);
    wire        wr_oc      = wr_pend_q && (addr_q == REG_OC_INH);
    wire        wr_delay   = wr_pend_q && (addr_q == REG_DELAY);
    wire        wr_links   = wr_pend_q && (addr_q == REG_LINKS);
    wire [15:0] wr_half    = hwdata[15:0];
    // Out of range settings are clamped to the nearest legal value.
    wire [15:0] neg_i_clamp = (wr_half < NEG_I_INH_MIN) ? NEG_I_INH_MIN :
                              (wr_half > NEG_I_INH_MAX) ? NEG_I_INH_MAX : wr_half; // see RULE2
    wire [15:0] oc_clamp    = (wr_half < OC_INH_MIN) ? OC_INH_MIN :
                              (wr_half > OC_INH_MAX) ? OC_INH_MAX : wr_half;       // see RULE9
    wire [15:0] delay_clamp = (wr_half < DELAY_MIN) ? DELAY_MIN :
                              (wr_half > DELAY_MAX) ? DELAY_MAX : wr_half;         // see RULE10
    wire [31:0] status_word = {25'h0, early_ind_q, block_q, alarm_q, v_live_q == 3'h7,
                               state_q == ST_LATCHED, cond_any, breaker_aux_disconnect_input};
    wire [31:0] rd_mux = (word_addr == REG_CTRL)      ? {28'h0000000, nondir_q, 1'b0, auto_q, indicate_q} :
                         (word_addr == REG_NEG_I_INH) ? {16'h0000, neg_i_inh_q} :
                         (word_addr == REG_OC_INH)    ? {16'h0000, oc_inh_q} :
                         (word_addr == REG_DELAY)     ? {16'h0000, delay_q} :
                         (word_addr == REG_LINKS)     ? {24'h000000, links_q} :
                         (word_addr == REG_STATUS)    ? status_word : 32'h00000000;

    // Detectors.
    wire [15:0] old_a = hist_a[hist_ptr_q];
    wire [15:0] old_b = hist_b[hist_ptr_q];
    wire [15:0] old_c = hist_c[hist_ptr_q];
    wire [15:0] diff_a = (phase_current_a > old_a) ? phase_current_a - old_a : old_a - phase_current_a; // see RULE3
    wire [15:0] diff_b = (phase_current_b > old_b) ? phase_current_b - old_b : old_b - phase_current_b;
    wire [15:0] diff_c = (phase_current_c > old_c) ? phase_current_c - old_c : old_c - phase_current_c;
    wire        hist_full  = hist_fill_q == CYCLE_SAMPLES[$clog2(CYCLE_SAMPLES):0];
    wire [2:0]  delta_d    = hist_full ? {diff_c > SUPERIMPOSED_THR, diff_b > SUPERIMPOSED_THR,
                                          diff_a > SUPERIMPOSED_THR} : 3'h0;            // see RULE6
    wire        any_delta  = |delta_q;                                                  // see RULE20
    wire        neg_i_inh  = neg_seq_current > neg_i_inh_q;
    wire        oc_any     = (phase_current_a > oc_inh_q) || (phase_current_b > oc_inh_q) ||
                             (phase_current_c > oc_inh_q);
    wire        all_dead   = v_live_q == 3'h0;
    wire        cond_nps   = (neg_seq_voltage > NEG_SEQ_V_THRESH) && !neg_i_inh;        // see RULE1
    wire        cond_3ph   = all_dead && !any_delta;                                    // see RULE4
    wire        cond_energ = live_line && all_dead && any_delta && !oc_any;             // see RULE7, RULE8
    assign      cond_any   = cond_nps || cond_3ph || cond_energ;
    // Before latching either inhibit removes the block at once.
    wire        inhibit    = neg_i_inh || oc_any;                                       // see RULE11
    wire        delay_done = (step_cnt_q >= delay_q) && (state_q == ST_TIMING);
    wire        cyc_tick   = cyc_cnt_q == 24'(DELAY_STEP_CYCLES - 1);
    wire        restored   = v_live_q == 3'h7;
    wire        clear_man  = !auto_q && reset_cmd_q && !cond_any;                       // see RULE12
    wire        clear_auto = auto_q && restored;                                        // see RULE13
    wire        sup_active = (state_q == ST_LATCHED) || breaker_aux_disconnect_input ||
                             ((state_q == ST_TIMING) && !inhibit);
    wire        block_d    = !indicate_q && sup_active;                                 // see RULE14
    wire        alarm_d    = (state_q == ST_LATCHED) || breaker_aux_disconnect_input || early_ind_q; // see RULE15
    wire [NUM_ELEMENTS-1:0] elem_d = block_d ? links_q : '0;                            // see RULE17
    wire        nondir_d   = block_d && nondir_q && !indicate_q;                        // see RULE18

    // Per phase hysteresis: hold state between 10V and 30V.
    function automatic logic level_next(input logic cur, input logic [15:0] v);
        level_next = cur ? (v >= PHASE_V_DROPOFF) : (v > PHASE_V_PICKUP);
    endfunction

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            indicate_q  <= 1'b0;
            auto_q      <= 1'b0;
            nondir_q    <= 1'b0;
            neg_i_inh_q <= NEG_I_INH_DEF;
            oc_inh_q    <= OC_INH_DEF;
            delay_q     <= DELAY_DEF;
            links_q     <= '0;
            reset_cmd_q <= 1'b0;
        end else begin
            reset_cmd_q <= wr_ctrl && hwdata[CTRL_RESET];
            if (wr_ctrl) begin
                indicate_q <= hwdata[CTRL_INDICATE];
                auto_q     <= hwdata[CTRL_AUTO];
                nondir_q   <= hwdata[CTRL_NONDIR];
            end
            if (wr_neg_i) begin
                neg_i_inh_q <= neg_i_clamp;
            end
            if (wr_oc) begin
                oc_inh_q <= oc_clamp;
            end
            if (wr_delay) begin
                delay_q <= delay_clamp;
            end
            if (wr_links) begin
                links_q <= hwdata[NUM_ELEMENTS-1:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_pend_q <= 1'b0;
            addr_q    <= 8'h00;
            hrdata_q  <= 32'h00000000;
        end else begin
            wr_pend_q <= bus_take && hwrite;
            addr_q    <= word_addr;
            if (bus_take && !hwrite) begin
                hrdata_q <= rd_mux;
            end
        end
    end

    // The history is not reset; the fill counter masks it until one full cycle is stored.
    always_ff @(posedge clk) begin
        if (sample_valid) begin
            hist_a[hist_ptr_q] <= phase_current_a;
            hist_b[hist_ptr_q] <= phase_current_b;
            hist_c[hist_ptr_q] <= phase_current_c;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hist_ptr_q  <= '0;
            hist_fill_q <= '0;
            v_live_q    <= 3'h7;
            delta_q     <= 3'h0;
        end else if (sample_valid) begin
            hist_ptr_q  <= hist_ptr_q + 1'b1;
            hist_fill_q <= hist_full ? hist_fill_q : hist_fill_q + 1'b1;
            v_live_q    <= {level_next(v_live_q[2], phase_voltage_c), level_next(v_live_q[1], phase_voltage_b),
                            level_next(v_live_q[0], phase_voltage_a)};                  // see RULE5
            delta_q     <= delta_d;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q     <= ST_IDLE;
            step_cnt_q  <= 16'h0000;
            cyc_cnt_q   <= 24'h000000;
            early_ind_q <= 1'b0;
        end else begin
            cyc_cnt_q <= (state_q != ST_TIMING || cyc_tick) ? 24'h000000 : cyc_cnt_q + 24'h000001;
            unique case (state_q)
                ST_IDLE: begin
                    step_cnt_q  <= 16'h0000;
                    early_ind_q <= 1'b0;
                    if (breaker_aux_disconnect_input) begin
                        state_q <= ST_LATCHED;                                          // see RULE19
                    end else if (cond_any && !inhibit) begin
                        state_q <= ST_TIMING;
                    end
                end
                ST_TIMING: begin
                    if (breaker_aux_disconnect_input || delay_done) begin
                        state_q <= ST_LATCHED;                                          // see RULE10
                    end else if (!cond_any || inhibit) begin
                        state_q <= ST_IDLE;
                    end
                    step_cnt_q <= cyc_tick ? step_cnt_q + 16'h0001 : step_cnt_q;
                    if (indicate_q && trip_signal) begin
                        early_ind_q <= 1'b1;                                            // see RULE16
                    end
                end
                ST_LATCHED: begin
                    early_ind_q <= 1'b0;
                    if (!breaker_aux_disconnect_input && (clear_man || clear_auto)) begin
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            block_q      <= 1'b0;
            alarm_q      <= 1'b0;
            elem_q       <= '0;
            nondir_out_q <= 1'b0;
        end else begin
            block_q      <= block_d;
            alarm_q      <= alarm_d;
            elem_q       <= elem_d;
            nondir_out_q <= nondir_d;
        end
    end

    assign hrdata                 = hrdata_q;
    assign hreadyout              = 1'b1;
    assign hresp                  = 1'b0;
    assign vt_supervision_block   = block_q;
    assign vt_supervision_alarm   = alarm_q;
    assign element_block          = elem_q;
    assign nondirectional_convert = nondir_out_q;
endmodule
`default_nettype wire

// ===== core/vt_supervision_pkg.sv
// Package with constants for the voltage transformer supervision block.
package vt_supervision_pkg;
    localparam int unsigned CLK_HZ            = 10_000_000;
    // Quantities are unsigned magnitudes: volts in 0.1 V units, currents in 0.01 In units.
    localparam logic [15:0] NEG_SEQ_V_THRESH  = 16'h0064;
    localparam logic [15:0] PHASE_V_DROPOFF   = 16'h0064;
    localparam logic [15:0] PHASE_V_PICKUP    = 16'h012c;
    localparam logic [15:0] SUPERIMPOSED_THR  = 16'h000a;
    localparam logic [15:0] NEG_I_INH_MIN     = 16'h0005;
    localparam logic [15:0] NEG_I_INH_MAX     = 16'h0032;
    localparam logic [15:0] NEG_I_INH_DEF     = 16'h0005;
    localparam logic [15:0] OC_INH_MIN        = 16'h0008;
    localparam logic [15:0] OC_INH_MAX        = 16'h0c80;
    localparam logic [15:0] OC_INH_DEF        = 16'h03e8;
    // Delay setting in 0.1 s steps.
    localparam logic [15:0] DELAY_MIN         = 16'h000a;
    localparam logic [15:0] DELAY_MAX         = 16'h0064;
    localparam logic [15:0] DELAY_DEF         = 16'h0032;
    localparam int unsigned DELAY_STEP_MS     = 100;
    localparam int unsigned DELAY_STEP_CYCLES = CLK_HZ / 1000 * DELAY_STEP_MS;
    // Samples per power cycle held for the superimposed current comparison.
    localparam int unsigned CYCLE_SAMPLES     = 16;
    localparam int unsigned NUM_ELEMENTS      = 8;
    // Register map.
    localparam logic [7:0] REG_CTRL      = 8'h00;
    localparam logic [7:0] REG_NEG_I_INH = 8'h04;
    localparam logic [7:0] REG_OC_INH    = 8'h08;
    localparam logic [7:0] REG_DELAY     = 8'h0c;
    localparam logic [7:0] REG_LINKS     = 8'h10;
    localparam logic [7:0] REG_STATUS    = 8'h14;
    localparam int unsigned CTRL_INDICATE = 0;
    localparam int unsigned CTRL_AUTO     = 1;
    localparam int unsigned CTRL_RESET    = 2;
    localparam int unsigned CTRL_NONDIR   = 3;
    typedef enum logic [1:0] {ST_IDLE, ST_TIMING, ST_LATCHED} sup_state_t;
endpackage

// ===== tb/vt_supervision_properties.sv
// Port level assertions for the voltage transformer supervision block.
`default_nettype none
module vt_supervision_properties
    import vt_supervision_pkg::*;
(
    input wire logic                    clk,
    input wire logic                    sys_rst,
    input wire logic                    breaker_aux_disconnect_input,
    input wire logic                    hsel,
    input wire logic [1:0]              htrans,
    input wire logic                    hwrite,
    input wire logic                    hready,
    input wire logic [31:0]             hrdata,
    input wire logic                    hresp,
    input wire logic                    vt_supervision_block,
    input wire logic                    vt_supervision_alarm,
    input wire logic [NUM_ELEMENTS-1:0] element_block,
    input wire logic                    nondirectional_convert
);
    timeunit 1ns;
    timeprecision 1ns;
    wire rd_req = hsel && hready && htrans[1] && !hwrite;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // The block outputs are registered, so a cycle of lag is allowed against the main block.
    sequence s_block_now_or_last;
        vt_supervision_block || $past(vt_supervision_block);
    endsequence
    sequence s_alarm_soon;
        ##[0:4] vt_supervision_alarm;
    endsequence
    a_elem_needs_block: assert property (|element_block |-> s_block_now_or_last)
        else $error("element block without supervision block");
    a_nondir_needs_block: assert property (nondirectional_convert |-> s_block_now_or_last)
        else $error("nondirectional conversion without block");
    a_aux_gives_alarm: assert property (breaker_aux_disconnect_input |-> s_alarm_soon)
        else $error("aux input did not raise supervision");
    // The block may stand before the delay expires, so only the fall of the indication is tied to it.
    a_block_has_alarm: assert property ($fell(vt_supervision_alarm) |-> !vt_supervision_block)
        else $error("indication cleared while block stands");
    a_aux_holds_block: assert property (breaker_aux_disconnect_input && vt_supervision_block |=> vt_supervision_block)
        else $error("block cleared while aux input held");
    a_alarm_fall_aux: assert property ($fell(vt_supervision_alarm) |-> !$past(breaker_aux_disconnect_input))
        else $error("indication cleared while aux input high");
    a_rdata_holds: assert property (!rd_req |=> $stable(hrdata))
        else $error("read data changed without a read");
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("bus response not okay");
endmodule
bind vt_supervision vt_supervision_properties chk_u (.clk(clk), .sys_rst(sys_rst),
    .breaker_aux_disconnect_input(breaker_aux_disconnect_input), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hrdata(hrdata), .hresp(hresp), .vt_supervision_block(vt_supervision_block),
    .vt_supervision_alarm(vt_supervision_alarm), .element_block(element_block),
    .nondirectional_convert(nondirectional_convert));
`default_nettype wire

// ===== tb/meas_front_model.sv
// Measurement front end model that presents samples at a fixed rate.
`default_nettype none
module meas_front_model #(
    parameter int unsigned PERIOD = 4
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic [7:0][15:0] meas_set,
    output logic                  sample_valid,
    output logic      [7:0][15:0] meas_q
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cnt_q;
    // New values appear only with a sample, so the block never sees a change between pulses.
    always_ff @(posedge clk) begin
        if (sys_rst || cnt_q == 8'(PERIOD - 1)) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
        sample_valid <= !sys_rst && cnt_q == 8'(PERIOD - 1);
        if (sys_rst || cnt_q == 8'(PERIOD - 1)) begin
            meas_q <= meas_set;
        end
    end
endmodule
`default_nettype wire

// ===== tb/tb_vt_supervision.sv
// Self-checking testbench for the voltage transformer supervision block.
`default_nettype none
module tb_vt_supervision
    import vt_supervision_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, trip = 1'b0, live = 1'b0, aux = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, blk, alm, nondir, sample_valid;
    logic [7:0] elem;
    logic [7:0][15:0] meas_set = {16'h0, 16'h0, {3{16'h0064}}, {3{16'h0898}}};
    logic [7:0][15:0] meas_q;
    int fail_count = 0, checks = 0, cyc = 0;
    always #50 clk = ~clk;
    meas_front_model #(.PERIOD(4)) fe_u (.clk(clk), .sys_rst(sys_rst), .meas_set(meas_set),
        .sample_valid(sample_valid), .meas_q(meas_q));
    vt_supervision dut_u (.clk(clk), .sys_rst(sys_rst), .sample_valid(sample_valid),
        .phase_voltage_a(meas_q[0]), .phase_voltage_b(meas_q[1]), .phase_voltage_c(meas_q[2]),
        .phase_current_a(meas_q[3]), .phase_current_b(meas_q[4]), .phase_current_c(meas_q[5]),
        .neg_seq_voltage(meas_q[6]), .neg_seq_current(meas_q[7]), .live_line(live),
        .breaker_aux_disconnect_input(aux), .trip_signal(trip), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .vt_supervision_block(blk), .vt_supervision_alarm(alm),
        .element_block(elem), .nondirectional_convert(nondir));
    task automatic test_done();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            test_done();
        end
    end
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), rd, e);
    endtask
    task automatic st(input int b, input logic e);
        bus(1'b0, REG_STATUS, 32'h0);
        chk($sformatf("status bit %0d", b), {31'h0, rd[b]}, {31'h0, e});
    endtask
    task automatic smp(input int n);
        repeat (n * 4) @(posedge clk);
    endtask
    task automatic setv(input logic [15:0] v);
        for (int k = 0; k < 3; k++) meas_set[k] <= v;
        smp(3);
    endtask
    task automatic t_regs();
        logic [7:0] a[6] = '{REG_NEG_I_INH, REG_NEG_I_INH, REG_OC_INH, REG_OC_INH, REG_DELAY, REG_DELAY};
        logic [31:0] d[6] = '{32'h1, 32'h64, 32'h0, 32'hffff, 32'h1, 32'hff};
        logic [31:0] e[6] = '{32'h5, 32'h32, 32'h8, 32'hc80, 32'ha, 32'h64};
        rdchk(REG_CTRL, 32'h0);
        rdchk(REG_NEG_I_INH, 32'h5);
        rdchk(REG_OC_INH, 32'h3e8);
        rdchk(REG_DELAY, 32'h32);
        bus(1'b1, 8'h18, 32'hffff);
        rdchk(8'h18, 32'h0);
        for (int k = 0; k < 6; k++) begin
            bus(1'b1, a[k], d[k]);
            rdchk(a[k], e[k]);
        end
    endtask
    task automatic t_detect();
        bus(1'b1, REG_NEG_I_INH, 32'h14);
        meas_set[6] <= 16'h00c8;
        meas_set[7] <= 16'h000a;
        smp(3);
        st(1, 1'b1);
        meas_set[7] <= 16'h001e;
        smp(3);
        st(1, 1'b0);
        meas_set[6] <= 16'h0032;
        meas_set[7] <= 16'h0000;
        smp(3);
        st(1, 1'b0);
        meas_set[6] <= 16'h0000;
        setv(16'h00c8);
        st(3, 1'b1);
        setv(16'h0032);
        st(3, 1'b0);
        setv(16'h00c8);
        st(3, 1'b0);
        setv(16'h0136);
        st(3, 1'b1);
        setv(16'h0898);
        smp(20);
        meas_set[4] <= 16'h0078;
        setv(16'h0000);
        st(1, 1'b0);
        smp(20);
        st(1, 1'b1);
        live <= 1'b1;
        meas_set[4] <= 16'h008c;
        smp(3);
        st(1, 1'b1);
        meas_set[4] <= 16'h0d00;
        smp(3);
        st(1, 1'b0);
        live <= 1'b0;
        meas_set[4] <= 16'h0064;
        setv(16'h0898);
        smp(20);
    endtask
    task automatic t_aux();
        bus(1'b1, REG_LINKS, 32'ha5);
        bus(1'b1, REG_CTRL, 32'h8);
        aux <= 1'b1;
        smp(1);
        chk("block", {31'h0, blk}, 32'h1);
        chk("alarm", {31'h0, alm}, 32'h1);
        chk("elements", {24'h0, elem}, 32'ha5);
        chk("nondir", {31'h0, nondir}, 32'h1);
        aux <= 1'b0;
        smp(2);
        chk("block kept", {31'h0, blk}, 32'h1);
        bus(1'b1, REG_CTRL, 32'hc);
        smp(1);
        chk("block manual clear", {31'h0, blk}, 32'h0);
        bus(1'b1, REG_CTRL, 32'h2);
        aux <= 1'b1;
        smp(1);
        aux <= 1'b0;
        smp(2);
        chk("block auto clear", {31'h0, blk}, 32'h0);
    endtask
    task automatic t_indicate();
        bus(1'b1, REG_CTRL, 32'hb);
        aux <= 1'b1;
        smp(1);
        chk("ind alarm", {31'h0, alm}, 32'h1);
        chk("ind block", {31'h0, blk}, 32'h0);
        chk("ind nondir", {31'h0, nondir}, 32'h0);
        chk("ind elements", {24'h0, elem}, 32'h0);
        aux <= 1'b0;
        smp(2);
        bus(1'b1, REG_CTRL, 32'h1);
        meas_set[6] <= 16'h00c8;
        smp(3);
        chk("no early alarm", {31'h0, alm}, 32'h0);
        trip <= 1'b1;
        smp(1);
        chk("early alarm", {31'h0, alm}, 32'h1);
        trip <= 1'b0;
        meas_set[6] <= 16'h0000;
        smp(3);
        chk("early alarm gone", {31'h0, alm}, 32'h0);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        t_regs();
        t_detect();
        t_aux();
        t_indicate();
        test_done();
    end
endmodule
`default_nettype wire
